// ### rtl/adc_cfg_pkg.sv
package adc_cfg_pkg;
  localparam int NUM_CH = 2;
  localparam int ADC_W = 11;

  // register offsets
  localparam logic [7:0] ADDR_CHAN_INDEX = 8'h05;
  localparam logic [7:0] ADDR_SELF_TEST = 8'h0e;
  localparam logic [7:0] ADDR_OFFSET_TRIM = 8'h10;
  localparam logic [7:0] ADDR_OUT_FORMAT = 8'h14;
  localparam logic [7:0] ADDR_CLK_PHASE = 8'h16;
  localparam logic [7:0] ADDR_DCO_DELAY = 8'h17;
  localparam logic [7:0] ADDR_REF_SPAN = 8'h18;
  localparam logic [7:0] ADDR_SIG_LOW = 8'h24;
  localparam logic [7:0] ADDR_SIG_HIGH = 8'h25;
  localparam logic [7:0] ADDR_TRANSFER = 8'hff;

  // reset values
  localparam logic [7:0] RST_CHAN_INDEX = 8'h03;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_REF_SPAN = 8'hc0;

  // writable bit masks, open bits read as zero
  localparam logic [7:0] MASK_CHAN_INDEX = 8'h03;
  localparam logic [7:0] MASK_SELF_TEST = 8'h05;
  localparam logic [7:0] MASK_OFFSET = 8'h3f;
  localparam logic [7:0] MASK_OUT_LOCAL = 8'h17;
  localparam logic [7:0] MASK_OUT_GLOBAL = 8'hc0;
  localparam logic [7:0] MASK_CLK_PHASE = 8'h87;
  localparam logic [7:0] MASK_DCO_DELAY = 8'h1f;
  localparam logic [7:0] MASK_REF_SPAN = 8'hc0;

  // field positions
  localparam int BIT_TEST_EN = 0;
  localparam int BIT_TEST_RESEQ = 2;
  localparam int BIT_DRIVE = 7;
  localparam int BIT_OUT_TYPE = 6;
  localparam int BIT_OUT_EN_N = 4;
  localparam int BIT_INVERT = 2;
  localparam int BIT_FMT_LO = 0;
  localparam int BIT_DCO_INV = 7;
  localparam int BIT_PHASE_LO = 0;
  localparam int BIT_SPAN_LO = 6;
  localparam int BIT_TRANSFER = 0;

  // output data clock delay: step = full delay / code span
  localparam int DCO_FULL_PS = 2500;
  localparam int DCO_CODE_MAX = 31;

  // signature generator
  localparam logic [15:0] SIG_SEED = 16'h0000;
  localparam logic [15:0] SIG_TAPS = 16'h1021;

  typedef struct packed {
    logic [7:0] self_test;
    logic [7:0] offset;
    logic [7:0] out_local;
  } chan_cfg_t;

  typedef struct packed {
    logic [7:0] out_global;
    logic [7:0] clk_phase;
    logic [7:0] dco_delay;
    logic [7:0] ref_span;
  } glob_cfg_t;

  typedef struct packed {
    logic [1:0] format;
    logic invert;
    logic out_enable_n;
    logic [5:0] offset;
  } chan_out_t;
endpackage

// ### rtl/adc_output_config_registers.sv
`timescale 1ns/1ps
`default_nettype none
module adc_output_config_registers
  import adc_cfg_pkg::*;
#(
  parameter int CHANNELS = NUM_CH,
  parameter int DATA_W = ADC_W
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // register port from the serial control logic
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // converter samples for the self-test
  input wire logic [CHANNELS*DATA_W-1:0] sample_data,
  // global output controls
  output logic drive_reduced,
  output logic lvds_mode,
  output logic [2:0] divider_delay_cycles,
  output logic output_data_clock_invert,
  output logic [4:0] output_data_clock_delay_code,
  output logic [11:0] output_data_clock_delay_ps,
  output logic [1:0] span_code,
  // per channel controls
  output chan_out_t [CHANNELS-1:0] chan_out,
  output logic [CHANNELS-1:0] self_test_running
);

  // the channel index register has one bit per channel, so the decode is fixed at two
  if (CHANNELS != NUM_CH) begin : gen_bad_channels
    $error("channel index decode serves exactly two channels");
  end
  if (DATA_W < 1 || DATA_W > 16) begin : gen_bad_width
    $error("sample width must be 1 to 16 bits");
  end

  // staged (master) and active (slave) copies
  chan_cfg_t [CHANNELS-1:0] stage_ch;
  chan_cfg_t [CHANNELS-1:0] active_ch;
  glob_cfg_t stage_gl;
  glob_cfg_t active_gl;
  logic [7:0] chan_index;
  logic [CHANNELS-1:0][15:0] signature;

  // decode
  wire hit_index = reg_addr == ADDR_CHAN_INDEX;
  wire hit_test = reg_addr == ADDR_SELF_TEST;
  wire hit_offset = reg_addr == ADDR_OFFSET_TRIM;
  wire hit_outfmt = reg_addr == ADDR_OUT_FORMAT;
  wire hit_phase = reg_addr == ADDR_CLK_PHASE;
  wire hit_dco = reg_addr == ADDR_DCO_DELAY;
  wire hit_span = reg_addr == ADDR_REF_SPAN;
  wire hit_sig_lo = reg_addr == ADDR_SIG_LOW;
  wire hit_sig_hi = reg_addr == ADDR_SIG_HIGH;
  wire hit_xfer = reg_addr == ADDR_TRANSFER;
  // the copy is taken on the edge that takes the transfer write; outputs follow one edge later
  wire transfer_now = reg_wr && hit_xfer && reg_wdata[BIT_TRANSFER];

  // global write strobes, one per register; the index write is not staged
  wire wr_index = reg_wr && hit_index;
  wire wr_outfmt = reg_wr && hit_outfmt;
  wire wr_phase = reg_wr && hit_phase;
  wire wr_dco = reg_wr && hit_dco;
  wire wr_span = reg_wr && hit_span;

  // the index is not staged, since it must steer the very next local write
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      chan_index <= RST_CHAN_INDEX;
    end else if (wr_index) begin
      chan_index <= reg_wdata & MASK_CHAN_INDEX;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      stage_gl.out_global <= RST_ZERO;
    end else if (wr_outfmt) begin
      stage_gl.out_global <= reg_wdata & MASK_OUT_GLOBAL;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      stage_gl.clk_phase <= RST_ZERO;
    end else if (wr_phase) begin
      stage_gl.clk_phase <= reg_wdata & MASK_CLK_PHASE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      stage_gl.dco_delay <= RST_ZERO;
    end else if (wr_dco) begin
      stage_gl.dco_delay <= reg_wdata & MASK_DCO_DELAY;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      stage_gl.ref_span <= RST_REF_SPAN;
    end else if (wr_span) begin
      stage_gl.ref_span <= reg_wdata & MASK_REF_SPAN;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      active_gl <= '{RST_ZERO, RST_ZERO, RST_ZERO, RST_REF_SPAN};
    end else if (transfer_now) begin
      active_gl <= stage_gl;
    end
  end

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : gen_ch
      wire local_wr = reg_wr && chan_index[g];
      wire [DATA_W-1:0] smp = sample_data[g*DATA_W +: DATA_W];
      wire test_en = active_ch[g].self_test[BIT_TEST_EN];
      wire test_reseq = active_ch[g].self_test[BIT_TEST_RESEQ];
      wire feedback = signature[g][15];
      wire [15:0] shifted = {signature[g][14:0], 1'b0} ^ (feedback ? SIG_TAPS : 16'h0000);
      wire [15:0] next_signature = shifted ^ {{(16-DATA_W){1'b0}}, smp};

      // a local write lands only in the channels that the index selects
      wire wr_test = local_wr && hit_test;
      wire wr_offset = local_wr && hit_offset;
      wire wr_local_fmt = local_wr && hit_outfmt;

      always_ff @(posedge core_clk) begin
        if (!rstn) begin
          stage_ch[g].self_test <= RST_ZERO;
        end else if (wr_test) begin
          stage_ch[g].self_test <= reg_wdata & MASK_SELF_TEST;
        end
      end

      always_ff @(posedge core_clk) begin
        if (!rstn) begin
          stage_ch[g].offset <= RST_ZERO;
        end else if (wr_offset) begin
          stage_ch[g].offset <= reg_wdata & MASK_OFFSET;
        end
      end

      always_ff @(posedge core_clk) begin
        if (!rstn) begin
          stage_ch[g].out_local <= RST_ZERO;
        end else if (wr_local_fmt) begin
          stage_ch[g].out_local <= reg_wdata & MASK_OUT_LOCAL;
        end
      end

      always_ff @(posedge core_clk) begin
        if (!rstn) begin
          active_ch[g] <= '{RST_ZERO, RST_ZERO, RST_ZERO};
        end else if (transfer_now) begin
          active_ch[g] <= stage_ch[g];
        end
      end

      // signature holds its last value when the test is stopped, so it can be read afterwards
      always_ff @(posedge core_clk) begin
        if (!rstn) begin
          signature[g] <= SIG_SEED;
        end else if (test_reseq) begin
          signature[g] <= SIG_SEED;
        end else if (test_en) begin
          signature[g] <= next_signature;
        end
      end

      always_ff @(posedge core_clk) begin
        if (!rstn) begin
          chan_out[g] <= '0;
        end else begin
          chan_out[g].format <= active_ch[g].out_local[BIT_FMT_LO +: 2];
          chan_out[g].invert <= active_ch[g].out_local[BIT_INVERT];
          chan_out[g].out_enable_n <= active_ch[g].out_local[BIT_OUT_EN_N];
          chan_out[g].offset <= active_ch[g].offset[5:0];
        end
      end

      always_ff @(posedge core_clk) begin
        if (!rstn) begin
          self_test_running[g] <= 1'b0;
        end else begin
          self_test_running[g] <= test_en && !test_reseq;
        end
      end
    end
  endgenerate

  // global controls
  wire [4:0] dco_code = active_gl.dco_delay[4:0];
  wire [16:0] dco_product = 17'(DCO_FULL_PS) * {12'h000, dco_code};
  wire [16:0] dco_quot = dco_product / 17'(DCO_CODE_MAX);
  // integer division truncates; one count of 31 is about 81 ps, enough for the delay line select

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      drive_reduced <= 1'b0;
    end else begin
      drive_reduced <= active_gl.out_global[BIT_DRIVE];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      lvds_mode <= 1'b0;
    end else begin
      lvds_mode <= active_gl.out_global[BIT_OUT_TYPE];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      divider_delay_cycles <= 3'h0;
    end else begin
      divider_delay_cycles <= active_gl.clk_phase[BIT_PHASE_LO +: 3];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      output_data_clock_invert <= 1'b0;
    end else begin
      output_data_clock_invert <= active_gl.clk_phase[BIT_DCO_INV];
    end
  end

  // the raw code goes out beside the figure in ps, so the delay line can use either
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      output_data_clock_delay_code <= 5'h00;
    end else begin
      output_data_clock_delay_code <= dco_code;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      output_data_clock_delay_ps <= 12'h000;
    end else begin
      output_data_clock_delay_ps <= dco_quot[11:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      span_code <= RST_REF_SPAN[BIT_SPAN_LO +: 2];
    end else begin
      span_code <= active_gl.ref_span[BIT_SPAN_LO +: 2];
    end
  end

  // readback shows staged values; local reads follow the lowest selected channel
  wire rd_ch = !chan_index[0];
  wire [15:0] rd_sig = signature[rd_ch];
  wire [7:0] rd_mux =
    hit_index ? chan_index :
    hit_test ? stage_ch[rd_ch].self_test :
    hit_offset ? stage_ch[rd_ch].offset :
    hit_outfmt ? (stage_gl.out_global | stage_ch[rd_ch].out_local) :
    hit_phase ? stage_gl.clk_phase :
    hit_dco ? stage_gl.dco_delay :
    hit_span ? stage_gl.ref_span :
    hit_sig_lo ? rd_sig[7:0] :
    hit_sig_hi ? rd_sig[15:8] :
    8'h00;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
    end
  end

  // read data holds until the next read, so the serial side may shift it out late
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

endmodule
`default_nettype wire

// ### test/adc_cfg_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module adc_cfg_assertions
  import adc_cfg_pkg::*;
#(
  parameter int CHANNELS = NUM_CH,
  parameter int DATA_W = ADC_W
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // converter samples and controls
  input wire logic [CHANNELS*DATA_W-1:0] sample_data,
  input wire logic drive_reduced,
  input wire logic lvds_mode,
  input wire logic output_data_clock_invert,
  input wire logic [2:0] divider_delay_cycles,
  input wire logic [4:0] output_data_clock_delay_code,
  input wire logic [11:0] output_data_clock_delay_ps,
  input wire logic [1:0] span_code,
  input wire chan_out_t [CHANNELS-1:0] chan_out,
  input wire logic [CHANNELS-1:0] self_test_running
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire logic xfer = reg_wr && reg_addr == ADDR_TRANSFER && reg_wdata[BIT_TRANSFER];
  wire logic rd_map = reg_addr inside {ADDR_CHAN_INDEX, ADDR_SELF_TEST, ADDR_OFFSET_TRIM,
    ADDR_OUT_FORMAT, ADDR_CLK_PHASE, ADDR_DCO_DELAY, ADDR_REF_SPAN, ADDR_SIG_LOW, ADDR_SIG_HIGH};
  AST_RVALID: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  AST_RDATA_HOLD: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  // settings may only move as a group, two edges after a transfer
  AST_XFER_ONLY: assert property (!$past(xfer, 2) |-> $stable({drive_reduced, lvds_mode,
    divider_delay_cycles, output_data_clock_invert, output_data_clock_delay_code, span_code,
    chan_out, self_test_running})) else $error("setting changed without transfer");
  AST_DELAY_PS: assert property (output_data_clock_delay_ps ==
    12'((DCO_FULL_PS * output_data_clock_delay_code) / DCO_CODE_MAX)) else $error("delay ps");
  AST_RESET_SPAN: assert property ($rose(rstn) |-> span_code == 2'h3 && !lvds_mode)
    else $error("reset output values");
  AST_UNMAPPED: assert property (reg_rd && !rd_map |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_OPEN_PHASE: assert property (reg_rd && reg_addr == ADDR_CLK_PHASE |=> !(|reg_rdata[6:3]))
    else $error("phase open bits");
  AST_OPEN_DELAY: assert property (reg_rd && reg_addr == ADDR_DCO_DELAY |=> !(|reg_rdata[7:5]))
    else $error("delay open bits");
  AST_OPEN_SPAN: assert property (reg_rd && reg_addr == ADDR_REF_SPAN |=> !(|reg_rdata[5:0]))
    else $error("span open bits");
endmodule
bind adc_output_config_registers adc_cfg_assertions #(.CHANNELS(CHANNELS), .DATA_W(DATA_W))
  u_chk (.core_clk(core_clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .sample_data(sample_data), .drive_reduced(drive_reduced), .lvds_mode(lvds_mode),
  .output_data_clock_invert(output_data_clock_invert),
  .divider_delay_cycles(divider_delay_cycles),
  .output_data_clock_delay_code(output_data_clock_delay_code),
  .output_data_clock_delay_ps(output_data_clock_delay_ps), .span_code(span_code),
  .chan_out(chan_out), .self_test_running(self_test_running));
`default_nettype wire

// ### test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module testbench
  import adc_cfg_pkg::*;
;
  logic core_clk, rstn, reg_wr, reg_rd, reg_rvalid, drive_reduced, lvds_mode, inv;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [21:0] sample_data;
  logic [2:0] dly;
  logic [4:0] code;
  logic [11:0] ps;
  logic [1:0] span_code, run;
  chan_out_t [1:0] chan_out;
  int num_errors = 0, tests_run = 0, cycles = 0;
  logic [15:0] sig;
  logic [7:0] ra [9] = '{8'h05, 8'h0e, 8'h10, 8'h14, 8'h16, 8'h17, 8'h18, 8'h24, 8'h25};
  logic [7:0] rv [9] = '{8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hc0, 8'h00, 8'h00};
  adc_output_config_registers DUT (.core_clk(core_clk), .rstn(rstn), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .sample_data(sample_data), .drive_reduced(drive_reduced),
    .lvds_mode(lvds_mode), .divider_delay_cycles(dly), .output_data_clock_invert(inv),
    .output_data_clock_delay_code(code), .output_data_clock_delay_ps(ps),
    .span_code(span_code), .chan_out(chan_out), .self_test_running(run));
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      end_sim;
    end
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic do_reset;
    @(posedge core_clk) rstn <= 1'b0;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK("rvalid", 1'b1, reg_rvalid)
    `CHK("rdata", e, reg_rdata)
  endtask
  // signature after n enabled edges from the seed, for a constant sample
  function automatic logic [15:0] sig_model(input logic [15:0] smp, input int n);
    logic [15:0] s;
    s = SIG_SEED;
    for (int i = 0; i < n; i++) begin
      s = {s[14:0], 1'b0} ^ (s[15] ? SIG_TAPS : 16'h0000) ^ smp;
    end
    return s;
  endfunction
  // outputs move one edge after the taking edge of the transfer write; look one edge later
  task automatic xfer;
    wr(ADDR_TRANSFER, 8'h01);
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  initial begin
    core_clk = 1'b0;
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    sample_data = 22'h155aa5;
    do_reset;
    for (int i = 0; i < 9; i++) rd(ra[i], rv[i]);
    `CHK("span reset", 2'h3, span_code)
    rd(8'h30, 8'h00);
    rd(ADDR_TRANSFER, 8'h00);
    $display("test reset done");
    wr(ADDR_OUT_FORMAT, 8'hff);
    wr(ADDR_CHAN_INDEX, 8'h01);
    wr(ADDR_OFFSET_TRIM, 8'hff);
    `CHK("lvds early", 1'b0, lvds_mode)
    xfer;
    `CHK("drive", 1'b1, drive_reduced)
    `CHK("lvds", 1'b1, lvds_mode)
    `CHK("ch0", 10'h3ff, chan_out[0])
    `CHK("ch1", 10'h3c0, chan_out[1])
    rd(ADDR_OUT_FORMAT, 8'hd7);
    wr(ADDR_CHAN_INDEX, 8'h02);
    rd(ADDR_OFFSET_TRIM, 8'h00);
    wr(ADDR_CHAN_INDEX, 8'h03);
    $display("test output mode done");
    wr(ADDR_CLK_PHASE, 8'hff);
    wr(ADDR_DCO_DELAY, 8'h01);
    xfer;
    `CHK("phase", 3'h7, dly)
    `CHK("dco inv", 1'b1, inv)
    `CHK("code min", 5'h01, code)
    `CHK("ps min", 12'd80, ps)
    rd(ADDR_CLK_PHASE, 8'h87);
    wr(ADDR_DCO_DELAY, 8'hff);
    xfer;
    `CHK("code max", 5'h1f, code)
    `CHK("ps max", 12'd2500, ps)
    rd(ADDR_DCO_DELAY, 8'h1f);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_REF_SPAN, {c[1:0], 6'h3f});
      xfer;
      `CHK("span", c[1:0], span_code)
      rd(ADDR_REF_SPAN, {c[1:0], 6'h00});
    end
    $display("test clocks and span done");
    wr(ADDR_SELF_TEST, 8'hff);
    xfer;
    `CHK("test off", 2'b00, run)
    wr(ADDR_SELF_TEST, 8'h01);
    xfer;
    `CHK("test on", 2'b11, run)
    wr(ADDR_SIG_LOW, 8'haa);
    rd(ADDR_SELF_TEST, 8'h01);
    // ten edges run from the enabling transfer to the stopping one, the stopping taking edge counted but not the enabling one
    wr(ADDR_SELF_TEST, 8'h00);
    xfer;
    `CHK("test stopped", 2'b00, run)
    sig = sig_model({5'h00, sample_data[10:0]}, 10);
    rd(ADDR_SIG_LOW, sig[7:0]);
    rd(ADDR_SIG_HIGH, sig[15:8]);
    wr(ADDR_CHAN_INDEX, 8'h02);
    sig = sig_model({5'h00, sample_data[21:11]}, 10);
    rd(ADDR_SIG_LOW, sig[7:0]);
    rd(ADDR_SIG_HIGH, sig[15:8]);
    wr(ADDR_CHAN_INDEX, 8'h03);
    $display("test self test done");
    // a second reset in mid-run must bring back the documented defaults
    do_reset;
    rd(ADDR_OUT_FORMAT, 8'h00);
    rd(ADDR_SIG_LOW, SIG_SEED[7:0]);
    `CHK("lvds reset", 1'b0, lvds_mode)
    `CHK("run reset", 2'b00, run)
    $display("test second reset done");
    end_sim;
  end
endmodule
`default_nettype wire
